/* logic/qpd_pkg.sv */
// shared constants and helpers for the quadrature position decoder
package qpd_pkg;

   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = DATA_W / 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned WORD_LSB = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_ENCODER_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MAXIMUM_POSITION = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_POSITION_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_ENCODER_STATUS = 8'h0c;

   // encoder_control_register field positions
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_FORMAT_BIT = 1;
   localparam int unsigned CTRL_CAPTURE_BIT = 2;
   localparam int unsigned CTRL_INDEX_RESET_BIT = 3;

   // encoder_status_register field positions
   localparam int unsigned STAT_DIRECTION_BIT = 0;
   localparam int unsigned STAT_ERROR_BIT = 1;

   // signal_format_select encodings
   localparam logic FMT_QUADRATURE = 1'b0;
   localparam logic FMT_CLOCK_DIR = 1'b1;

   // edge_capture_select encodings
   localparam logic CAP_PHASE_A_ONLY = 1'b0;
   localparam logic CAP_BOTH_PHASES = 1'b1;

   // reset values and word constants
   localparam logic [DATA_W-1:0] CTRL_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] MAXPOS_RST = 32'hffffffff;
   localparam logic [DATA_W-1:0] POS_RST = 32'h00000000;
   localparam logic [DATA_W-1:0] POS_ONE = 32'h00000001;
   localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // byte-lane merge of a write into a stored word
   function automatic logic [DATA_W-1:0] qpd_merge(
      input logic [DATA_W-1:0] old_v,
      input logic [DATA_W-1:0] new_v,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : qpd_merge

endpackage : qpd_pkg

/* logic/qpd_step_decoder.sv */
// edge and direction decoder for the two encoder phases and the index
`timescale 1ns/1ps
module qpd_step_decoder (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // encoder pins, synchronous to sys_clk
   input wire logic phase_a_input,
   input wire logic phase_b_input,
   input wire logic index_input,
   // mode selection
   input wire logic signal_format_select,
   input wire logic edge_capture_select,
   // decoded events, one cycle each
   output logic step,
   output logic step_cw,
   output logic index_rise,
   output logic illegal
);
   import qpd_pkg::*;

   typedef struct packed {
      logic a;
      logic b;
      logic idx;
      logic primed;
   } qpd_dec_state_t;

   qpd_dec_state_t st_r;
   qpd_dec_state_t st_nxt;
   logic a_edge;
   logic b_edge;

   // decode by comparing the live pins with the last sample
   always_comb begin
      st_nxt = st_r;
      st_nxt.a = phase_a_input;
      st_nxt.b = phase_b_input;
      st_nxt.idx = index_input;
      // first sample after reset only primes, so pins high at release never count
      st_nxt.primed = 1'b1;
      a_edge = st_r.primed && (phase_a_input != st_r.a);
      b_edge = st_r.primed && (phase_b_input != st_r.b);
      index_rise = st_r.primed && index_input && !st_r.idx;
      step = 1'b0;
      step_cw = 1'b0;
      illegal = 1'b0;
      if (signal_format_select == FMT_QUADRATURE) begin
         // R4 quadrature phase decode
         if (a_edge && b_edge) begin
            illegal = 1'b1; // both phases moved, direction unknowable
         end else if (a_edge) begin
            // R6 direction from new state
            step = 1'b1;
            step_cw = (phase_a_input != phase_b_input);
         end else if (b_edge && (edge_capture_select == CAP_BOTH_PHASES)) begin
            // R5 phase b edges counted
            // R7 each edge tracked
            step = 1'b1;
            step_cw = (phase_b_input == phase_a_input);
         end
      end else begin
         // phase a is the count clock, phase b high means reverse
         if (a_edge && (phase_a_input || (edge_capture_select == CAP_BOTH_PHASES))) begin
            step = 1'b1;
            step_cw = !phase_b_input;
         end
      end
   end

   // sample register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{a: 1'b0, b: 1'b0, idx: 1'b0, primed: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : qpd_step_decoder

/* logic/qpd_top.sv */
// quadrature position decoder with axi4-lite register access
//
// Operation
// R1 - index reset deselected: an index pulse never clears the position
// R2 - index reset deselected: position clears only on reaching the maximum position
// R3 - index reset selected: position clears when the index pulse is seen
// R4 - format select zero: phases decoded as quadrature signals
// R5 - capture select one counts both phase edges, zero counts phase a only
// R6 - from both phases low a counterclockwise move decodes as counterclockwise
// R7 - reverse, forward once, reverse again from zero tracks edge by edge to -3
// R8 - clockwise steps increment the signed position, counterclockwise steps decrement
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module qpd_top (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // axi4-lite write address
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [qpd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   // axi4-lite write data
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [qpd_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic [qpd_pkg::STRB_W-1:0] S_AXI_WSTRB,
   // axi4-lite write response
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // axi4-lite read address
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [qpd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   // axi4-lite read data
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [qpd_pkg::DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // encoder pins
   input wire logic PHASE_A_INPUT,
   input wire logic PHASE_B_INPUT,
   input wire logic INDEX_INPUT,
   // live position and direction
   output logic [qpd_pkg::DATA_W-1:0] POSITION_COUNT_VALUE,
   output logic DIRECTION
);
   import qpd_pkg::*;

   // whole module state in one record
   typedef struct packed {
      logic enable;
      logic signal_format_select;
      logic edge_capture_select;
      logic index_reset_select;
      logic [DATA_W-1:0] maximum_position_register;
      logic [DATA_W-1:0] position_count_register;
      logic direction;
      logic error;
      logic aw_held;
      logic [ADDR_W-1:0] awaddr;
      logic w_held;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } qpd_state_t;

   localparam qpd_state_t ST_RST = '{
      enable: CTRL_RST[CTRL_ENABLE_BIT],
      signal_format_select: CTRL_RST[CTRL_FORMAT_BIT],
      edge_capture_select: CTRL_RST[CTRL_CAPTURE_BIT],
      index_reset_select: CTRL_RST[CTRL_INDEX_RESET_BIT],
      maximum_position_register: MAXPOS_RST,
      position_count_register: POS_RST,
      direction: 1'b0,
      error: 1'b0,
      aw_held: 1'b0,
      awaddr: '0,
      w_held: 1'b0,
      wdata: '0,
      wstrb: '0,
      bvalid: 1'b0,
      bresp: RESP_OKAY,
      rvalid: 1'b0,
      rdata: '0,
      rresp: RESP_OKAY
   };

   qpd_state_t st_r;
   qpd_state_t st_nxt;

   // decoder events
   logic step;
   logic step_cw;
   logic index_rise;
   logic illegal;

   // bus handshake terms
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_write;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;

   // register write decode
   logic wr_ctrl;
   logic wr_maxpos;
   logic wr_pos;
   logic wr_stat;
   logic [DATA_W-1:0] ctrl_word;
   logic [DATA_W-1:0] ctrl_merged;
   logic [DATA_W-1:0] pos_merged;
   logic [DATA_W-1:0] stat_merged;
   logic err_clear;

   // word match ignoring the byte-in-word bits
   function automatic logic reg_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs
   );
      return addr[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB];
   endfunction : reg_hit

   // any mapped register
   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      return reg_hit(addr, OFS_ENCODER_CONTROL) || reg_hit(addr, OFS_MAXIMUM_POSITION) ||
         reg_hit(addr, OFS_POSITION_COUNT) || reg_hit(addr, OFS_ENCODER_STATUS);
   endfunction : reg_mapped

   // pack the control bits as software sees them
   function automatic logic [DATA_W-1:0] pack_ctrl(input qpd_state_t s);
      logic [DATA_W-1:0] w;
      w = WORD_ZERO;
      w[CTRL_ENABLE_BIT] = s.enable;
      w[CTRL_FORMAT_BIT] = s.signal_format_select;
      w[CTRL_CAPTURE_BIT] = s.edge_capture_select;
      w[CTRL_INDEX_RESET_BIT] = s.index_reset_select;
      return w;
   endfunction : pack_ctrl

   // pack the status bits
   function automatic logic [DATA_W-1:0] pack_stat(input qpd_state_t s);
      logic [DATA_W-1:0] w;
      w = WORD_ZERO;
      w[STAT_DIRECTION_BIT] = s.direction;
      w[STAT_ERROR_BIT] = s.error;
      return w;
   endfunction : pack_stat

   // phase and index decode uses the registered mode bits
   qpd_step_decoder u_decoder (
      .sys_clk(SYS_CLK),
      .rst_b(RST_B),
      .phase_a_input(PHASE_A_INPUT),
      .phase_b_input(PHASE_B_INPUT),
      .index_input(INDEX_INPUT),
      .signal_format_select(st_r.signal_format_select),
      .edge_capture_select(st_r.edge_capture_select),
      .step(step),
      .step_cw(step_cw),
      .index_rise(index_rise),
      .illegal(illegal)
   );

   // ready terms; no new write is taken while a response waits
   assign S_AXI_AWREADY = !st_r.aw_held && !st_r.bvalid;
   assign S_AXI_WREADY = !st_r.w_held && !st_r.bvalid;
   assign S_AXI_ARREADY = !st_r.rvalid;
   assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
   assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   // address and data may come together or in either order
   assign wr_addr = st_r.aw_held ? st_r.awaddr : S_AXI_AWADDR;
   assign wr_data = st_r.w_held ? st_r.wdata : S_AXI_WDATA;
   assign wr_strb = st_r.w_held ? st_r.wstrb : S_AXI_WSTRB;
   assign do_write = (st_r.aw_held || aw_fire) && (st_r.w_held || w_fire);

   // register selects for the write that completes this cycle
   assign wr_ctrl = do_write && reg_hit(wr_addr, OFS_ENCODER_CONTROL);
   assign wr_maxpos = do_write && reg_hit(wr_addr, OFS_MAXIMUM_POSITION);
   assign wr_pos = do_write && reg_hit(wr_addr, OFS_POSITION_COUNT);
   assign wr_stat = do_write && reg_hit(wr_addr, OFS_ENCODER_STATUS);
   assign ctrl_word = pack_ctrl(st_r);
   assign ctrl_merged = qpd_merge(ctrl_word, wr_data, wr_strb);
   assign pos_merged = qpd_merge(st_r.position_count_register, wr_data, wr_strb);
   // error bit is write-one-to-clear, lanes still honoured
   assign stat_merged = qpd_merge(WORD_ZERO, wr_data, wr_strb);
   assign err_clear = wr_stat && stat_merged[STAT_ERROR_BIT];

   // next state
   always_comb begin
      st_nxt = st_r;

      // write channel capture
      if (aw_fire) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = S_AXI_AWADDR;
      end
      if (w_fire) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = S_AXI_WDATA;
         st_nxt.wstrb = S_AXI_WSTRB;
      end
      if (do_write) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = reg_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_r.bvalid && S_AXI_BREADY) begin
         st_nxt.bvalid = 1'b0;
      end

      // control and limit writes
      if (wr_ctrl) begin
         st_nxt.enable = ctrl_merged[CTRL_ENABLE_BIT];
         st_nxt.signal_format_select = ctrl_merged[CTRL_FORMAT_BIT];
         st_nxt.edge_capture_select = ctrl_merged[CTRL_CAPTURE_BIT];
         st_nxt.index_reset_select = ctrl_merged[CTRL_INDEX_RESET_BIT];
      end
      if (wr_maxpos) begin
         st_nxt.maximum_position_register =
            qpd_merge(st_r.maximum_position_register, wr_data, wr_strb);
      end

      // position update: index clear, then software load, then steps
      // R1 R3 index clears only when selected
      if (st_r.enable && st_r.index_reset_select && index_rise) begin
         st_nxt.position_count_register = POS_RST;
      end else if (wr_pos) begin
         st_nxt.position_count_register = pos_merged;
      end else if (st_r.enable && step) begin
         // R2 clear only at maximum
         // R8 count up or down
         if (step_cw) begin
            if (st_r.position_count_register == st_r.maximum_position_register) begin
               st_nxt.position_count_register = POS_RST;
            end else begin
               st_nxt.position_count_register = st_r.position_count_register + POS_ONE;
            end
         end else begin
            // below zero wraps to the maximum, mirror of the upward wrap
            if (st_r.position_count_register == POS_RST) begin
               st_nxt.position_count_register = st_r.maximum_position_register;
            end else begin
               st_nxt.position_count_register = st_r.position_count_register - POS_ONE;
            end
         end
      end

      // direction follows every counted step
      if (st_r.enable && step) begin
         st_nxt.direction = step_cw;
      end

      // sticky error; a new event in the clearing cycle keeps it set
      if (err_clear) begin
         st_nxt.error = 1'b0;
      end
      if (st_r.enable && illegal) begin
         st_nxt.error = 1'b1;
      end

      // read channel, answered one cycle after the address is taken
      if (ar_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = RESP_OKAY;
         if (reg_hit(S_AXI_ARADDR, OFS_ENCODER_CONTROL)) begin
            st_nxt.rdata = ctrl_word;
         end else if (reg_hit(S_AXI_ARADDR, OFS_MAXIMUM_POSITION)) begin
            st_nxt.rdata = st_r.maximum_position_register;
         end else if (reg_hit(S_AXI_ARADDR, OFS_POSITION_COUNT)) begin
            st_nxt.rdata = st_r.position_count_register;
         end else if (reg_hit(S_AXI_ARADDR, OFS_ENCODER_STATUS)) begin
            st_nxt.rdata = pack_stat(st_r);
         end else begin
            st_nxt.rdata = WORD_ZERO;
            st_nxt.rresp = RESP_SLVERR;
         end
      end else if (st_r.rvalid && S_AXI_RREADY) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   // single state register
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   assign S_AXI_BVALID = st_r.bvalid;
   assign S_AXI_BRESP = st_r.bresp;
   assign S_AXI_RVALID = st_r.rvalid;
   assign S_AXI_RDATA = st_r.rdata;
   assign S_AXI_RRESP = st_r.rresp;
   assign POSITION_COUNT_VALUE = st_r.position_count_register;
   assign DIRECTION = st_r.direction;

endmodule : qpd_top

/* bench/qpd_top_props.sv */
// port assertions for the quadrature position decoder
`timescale 1ns/1ps
module qpd_top_props (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [qpd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [qpd_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   // encoder pins and position
   input wire logic PHASE_A_INPUT,
   input wire logic PHASE_B_INPUT,
   input wire logic INDEX_INPUT,
   input wire logic [qpd_pkg::DATA_W-1:0] POSITION_COUNT_VALUE,
   input wire logic DIRECTION
);
   import qpd_pkg::*;
   // shadow of control, maximum and last pin sample
   typedef struct packed {
      logic [3:0] ctrl;
      logic [DATA_W-1:0] maxp;
      logic pa;
      logic pb;
      logic ix;
   } qpd_chk_t;
   qpd_chk_t st_r;
   qpd_chk_t st_nxt;
   logic wr, wpos, en, chg, cnt, iclr, irise;
   logic [1:0] df;
   logic [DATA_W-1:0] pos;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   // only writes taking address and data together are mirrored
   assign wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   assign wpos = wr && S_AXI_AWADDR == OFS_POSITION_COUNT;
   assign en = st_r.ctrl[CTRL_ENABLE_BIT];
   assign irise = INDEX_INPUT && !st_r.ix;
   assign iclr = en && st_r.ctrl[CTRL_INDEX_RESET_BIT] && irise;
   assign df = {PHASE_B_INPUT, PHASE_A_INPUT ^ PHASE_B_INPUT} - {st_r.pb, st_r.pa ^ st_r.pb};
   assign chg = PHASE_A_INPUT != st_r.pa;
   assign cnt = en && !st_r.ctrl[CTRL_FORMAT_BIT] && !wpos && !iclr
                && (st_r.ctrl[CTRL_CAPTURE_BIT] || chg);
   assign pos = POSITION_COUNT_VALUE;
   // next shadow state
   always_comb begin
      st_nxt = st_r;
      st_nxt.pa = PHASE_A_INPUT;
      st_nxt.pb = PHASE_B_INPUT;
      st_nxt.ix = INDEX_INPUT;
      if (wr && S_AXI_AWADDR == OFS_ENCODER_CONTROL) begin
         st_nxt.ctrl = S_AXI_WDATA[3:0];
      end
      if (wr && S_AXI_AWADDR == OFS_MAXIMUM_POSITION) begin
         st_nxt.maxp = S_AXI_WDATA;
      end
   end
   // shadow register
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_r <= {CTRL_RST[3:0], MAXPOS_RST, 3'h0};
      end else begin
         st_r <= st_nxt;
      end
   end
   cw_step_a: assert property (
      cnt && df == 2'h1 && pos != st_r.maxp |=> pos == $past(pos) + POS_ONE && DIRECTION)
      else $error("clockwise step miscounted");
   ccw_step_a: assert property (
      cnt && df == 2'h3 && pos != WORD_ZERO |=> pos == $past(pos) - POS_ONE && !DIRECTION)
      else $error("counterclockwise step miscounted");
   max_wrap_a: assert property (
      cnt && df == 2'h1 && pos == st_r.maxp |=> pos == WORD_ZERO)
      else $error("no clear at maximum");
   zero_wrap_a: assert property (
      cnt && df == 2'h3 && pos == WORD_ZERO |=> pos == $past(st_r.maxp))
      else $error("no wrap below zero");
   b_ignore_a: assert property (
      en && !st_r.ctrl[CTRL_FORMAT_BIT] && !st_r.ctrl[CTRL_CAPTURE_BIT] && !chg && !wpos
      && !iclr |=> $stable(pos))
      else $error("phase b edge counted");
   index_hold_a: assert property (
      en && !st_r.ctrl[CTRL_INDEX_RESET_BIT] && irise && df == 2'h0 && !wpos |=> $stable(pos))
      else $error("index cleared while deselected");
   index_clear_a: assert property (iclr |=> pos == WORD_ZERO)
      else $error("index did not clear");
   double_move_a: assert property (cnt && df == 2'h2 |=> $stable(pos))
      else $error("double transition counted");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read not answered");
endmodule : qpd_top_props

/* bench/qpd_encoder_model.sv */
// behavioural rotary encoder driving phase and index pins
`timescale 1ns/1ps
module qpd_encoder_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // commands from the bench
   input wire logic step_req,
   input wire logic step_cw,
   input wire logic jump_req,
   input wire logic index_req,
   // encoder pins
   output logic ph_a,
   output logic ph_b,
   output logic index_out
);
   // shaft phase and index level
   typedef struct packed {
      logic [1:0] q;
      logic ix;
   } qpd_enc_t;
   qpd_enc_t st_r;
   qpd_enc_t st_nxt;
   // gray order 00 10 11 01; a jump is a deliberate fault
   always_comb begin
      st_nxt = st_r;
      st_nxt.ix = index_req;
      if (jump_req) begin
         st_nxt.q = st_r.q + 2'h2;
      end else if (step_req) begin
         st_nxt.q = step_cw ? st_r.q + 2'h1 : st_r.q - 2'h1;
      end
   end
   // state register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // pins from phase
   assign ph_b = st_r.q[1];
   assign ph_a = st_r.q[1] ^ st_r.q[0];
   assign index_out = st_r.ix;
endmodule : qpd_encoder_model

/* bench/qpd_top_bench.sv */
// self-checking bench for the quadrature position decoder
`timescale 1ns/1ps
module qpd_top_bench;
   import qpd_pkg::*;
   logic clk, rst_b, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
   logic ar_valid, ar_ready, r_valid, r_ready, ph_a, ph_b, idx, dir;
   logic st_req, st_cw, jmp, ix_req, both, fmt;
   logic [ADDR_W-1:0] aw_addr, ar_addr;
   logic [DATA_W-1:0] w_data, r_data, pos_val, pos, maxp, r;
   logic [1:0] b_resp, r_resp, q;
   int errors, cmp_count;
   int seed = 32'hab020f6b;
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // device and encoder; protection and strobes stay fixed
   qpd_top u_qpd_top (
      .SYS_CLK(clk), .RST_B(rst_b),
      .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_AWADDR(aw_addr),
      .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
      .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(b_valid),
      .S_AXI_BREADY(b_ready), .S_AXI_BRESP(b_resp), .S_AXI_ARVALID(ar_valid),
      .S_AXI_ARREADY(ar_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARPROT(3'h0),
      .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .S_AXI_RDATA(r_data),
      .S_AXI_RRESP(r_resp), .PHASE_A_INPUT(ph_a), .PHASE_B_INPUT(ph_b),
      .INDEX_INPUT(idx), .POSITION_COUNT_VALUE(pos_val), .DIRECTION(dir)
   );
   qpd_encoder_model u_qpd_encoder_model (
      .clk(clk), .rst_b(rst_b), .step_req(st_req), .step_cw(st_cw), .jump_req(jmp),
      .index_req(ix_req), .ph_a(ph_a), .ph_b(ph_b), .index_out(idx)
   );
   // expected position after one counted step
   function automatic logic [DATA_W-1:0] nxt(input logic [DATA_W-1:0] p, input logic cw);
      if (cw) return (p == maxp) ? WORD_ZERO : p + POS_ONE;
      return (p == WORD_ZERO) ? maxp : p - POS_ONE;
   endfunction : nxt
   // compare and count
   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                        input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : check
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   // bus write: address and data offered together, no fixed latency assumed
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [1:0] er);
      @(posedge clk);
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      aw_addr <= a;
      w_data <= d;
      #1;
      while ((aw_ready && w_ready) !== 1'b1) begin @(posedge clk); #1; end
      @(posedge clk);
      aw_valid <= 1'b0;
      w_valid <= 1'b0;
      b_ready <= 1'b1;
      #1;
      while (b_valid !== 1'b1) begin @(posedge clk); #1; end
      check({30'h0, b_resp}, {30'h0, er}, "write response");
      @(posedge clk);
      b_ready <= 1'b0;
   endtask : axi_wr
   // bus read with data and response compare
   task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                         input logic [1:0] er);
      @(posedge clk);
      ar_valid <= 1'b1;
      ar_addr <= a;
      #1;
      while (ar_ready !== 1'b1) begin @(posedge clk); #1; end
      @(posedge clk);
      ar_valid <= 1'b0;
      r_ready <= 1'b1;
      #1;
      while (r_valid !== 1'b1) begin @(posedge clk); #1; end
      check(r_data, e, "read data");
      check({30'h0, r_resp}, {30'h0, er}, "read response");
      @(posedge clk);
      r_ready <= 1'b0;
   endtask : axi_rd
   task automatic mode(input logic [3:0] m);
      axi_wr(OFS_ENCODER_CONTROL, {28'h0, m}, RESP_OKAY);
      both = m[2];
      fmt = m[1];
   endtask : mode
   // one encoder step; phase a moves on cw from even phase, ccw from odd
   task automatic step(input logic cw);
      logic [1:0] n;
      n = cw ? q + 2'h1 : q - 2'h1;
      // clock and direction: phase a rising (either edge if both) counts, b high counts down
      if (fmt) begin
         if ((^n != ^q) && (both || ^n)) pos = nxt(pos, !n[1]);
      end else if (both || (cw ^ q[0])) pos = nxt(pos, cw);
      q = n;
      st_req <= 1'b1;
      st_cw <= cw;
      @(posedge clk);
      st_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(pos_val, pos, "position after step");
   endtask : step
   task automatic rnd_step();
      r = $random(seed);
      step(r[0]);
      repeat (r[2:1]) @(posedge clk);
   endtask : rnd_step
   task automatic pulse(input logic clr);
      ix_req <= 1'b1;
      repeat (3) @(posedge clk);
      ix_req <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      if (clr) pos = WORD_ZERO;
      check(pos_val, pos, "position after index");
   endtask : pulse
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
   // main sequence
   initial begin
      {rst_b, aw_valid, w_valid, b_ready, ar_valid, r_ready} = '0;
      {st_req, st_cw, jmp, ix_req, both, fmt, aw_addr, ar_addr, w_data, pos, q} = '0;
      maxp = MAXPOS_RST;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      axi_rd(OFS_ENCODER_CONTROL, CTRL_RST, RESP_OKAY);
      axi_rd(OFS_MAXIMUM_POSITION, MAXPOS_RST, RESP_OKAY);
      axi_rd(8'h40, WORD_ZERO, RESP_SLVERR);
      axi_wr(8'h44, POS_ONE, RESP_SLVERR);
      // reverse, forward once, reverse again, both edges counted
      mode(4'h5);
      step(1'b0);
      check({31'h0, dir}, WORD_ZERO, "first reverse direction");
      step(1'b0);
      step(1'b1);
      step(1'b0);
      step(1'b0);
      axi_rd(OFS_POSITION_COUNT, 32'hfffffffd, RESP_OKAY);
      // random walk in both capture modes
      repeat (30) rnd_step();
      mode(4'h1);
      repeat (30) rnd_step();
      // clock and direction format, rising edges only, then both phase a edges
      mode(4'h3);
      repeat (20) rnd_step();
      mode(4'h7);
      repeat (20) rnd_step();
      // small maximum, wrapping both ways
      mode(4'h5);
      axi_wr(OFS_MAXIMUM_POSITION, 32'h3, RESP_OKAY);
      maxp = 32'h3;
      axi_wr(OFS_POSITION_COUNT, 32'h2, RESP_OKAY);
      pos = 32'h2;
      repeat (3) step(1'b1);
      repeat (2) step(1'b0);
      check(pos_val, 32'h3, "wrap below zero");
      axi_wr(OFS_MAXIMUM_POSITION, MAXPOS_RST, RESP_OKAY);
      maxp = MAXPOS_RST;
      // index ignored, then index clears
      pulse(1'b0);
      mode(4'hd);
      step(1'b1);
      pulse(1'b1);
      step(1'b0);
      // both phases at once must not count
      jmp <= 1'b1;
      @(posedge clk);
      jmp <= 1'b0;
      q = q + 2'h2;
      repeat (2) @(posedge clk);
      #1;
      check(pos_val, pos, "double transition");
      step(1'b1);
      // sticky error from the double transition, cleared by writing one
      axi_rd(OFS_ENCODER_STATUS, 32'h3, RESP_OKAY);
      axi_wr(OFS_ENCODER_STATUS, 32'h2, RESP_OKAY);
      axi_rd(OFS_ENCODER_STATUS, 32'h1, RESP_OKAY);
      conclude();
   end
endmodule : qpd_top_bench
// attach the port checker to the decoder
bind qpd_top qpd_top_props u_qpd_top_props (
   .SYS_CLK(SYS_CLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .PHASE_A_INPUT(PHASE_A_INPUT), .PHASE_B_INPUT(PHASE_B_INPUT), .INDEX_INPUT(INDEX_INPUT),
   .POSITION_COUNT_VALUE(POSITION_COUNT_VALUE), .DIRECTION(DIRECTION)
);
